// ---- hw/sgpr_responder.sv ----
// Get-parameters command decoder and response byte streamer
`timescale 1ns/100ps
`include "sgpr_consts.svh"
module sgpr_responder
  import sgpr_pkg::*;
#(
  parameter int UNICAST_CNT   = 2,
  parameter int MULTICAST_CNT = 2,
  parameter int MIXED_CNT     = 2,
  parameter int VLAN_CNT      = 15,
  parameter int CHANNEL_CNT   = 1,
  parameter bit VMODE_PLUS    = 1'b1,
  parameter bit VMODE_ANY     = 1'b0
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         cmdValid,
  input  wire logic [7:0]   cmdType,
  input  wire logic         cmdChecksumOk,
  input  wire logic         cmdIdMatch,
  input  wire logic [127:0] cmdHeader,
  input  wire logic [383:0] macAddrs,
  input  wire logic [7:0]   macEnables,
  input  wire logic [239:0] vlanTags,
  input  wire logic [14:0]  vlanEnables,
  input  wire logic [31:0]  linkSettings,
  input  wire logic [31:0]  bcastSettings,
  input  wire logic         bcastFilterOn,
  input  wire logic         channelOn,
  input  wire logic         netTxOn,
  input  wire logic         mcastFilterOn,
  input  wire logic [7:0]   vlanMode,
  input  wire logic [7:0]   flowCtrlEnable,
  input  wire logic [31:0]  aenControl,
  input  wire logic         rspReady,
  output logic              busy,
  output logic              rspValid,
  output logic [7:0]        rspByte,
  output logic              rspLast,
  output logic [7:0]        capVlanCount,
  output logic [7:0]        capMixedCount,
  output logic [7:0]        capMcastCount,
  output logic [7:0]        capUcastCount,
  output logic [7:0]        capVlanModes,
  output logic [7:0]        capChannelCount
);
  localparam int MAC_CNT   = UNICAST_CNT + MULTICAST_CNT + MIXED_CNT;
  localparam int VAR_OFS   = `SGPR_OFS_MACS + 6 * MAC_CNT;
  localparam int TAG_END   = VAR_OFS + 2 * VLAN_CNT;
  localparam int PAY_END   = (TAG_END + 3) / 4 * 4;
  localparam int TOTAL     = PAY_END + 4;

  //==========================================================================
  // Parameter checks, refused at elaboration
  if (VLAN_CNT < 0 || VLAN_CNT > `SGPR_MAX_VLAN)  // RQ1
  begin : g_bad_vlan_cnt
    $error("VLAN filter count out of range");
  end
  if (UNICAST_CNT + MIXED_CNT < 1)  // RQ2
  begin : g_no_ucast
    $error("need a unicast or mixed filter");
  end
  if (UNICAST_CNT < 0 || MULTICAST_CNT < 0 || MIXED_CNT < 0)
  begin : g_neg_cnt
    $error("address filter count negative");
  end
  if (MAC_CNT > `SGPR_MAX_MAC)  // RQ3
  begin : g_mac_total
    $error("address filter total above limit");
  end
  if (CHANNEL_CNT < 1 || CHANNEL_CNT > 255)
  begin : g_bad_chan
    $error("channel count out of range");
  end
  if (TOTAL > 256)
  begin : g_idx_width
    $error("response too long for byte index");
  end

  //==========================================================================
  // Capability fields
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      capVlanCount    <= 8'h00;
      capMixedCount   <= 8'h00;
      capMcastCount   <= 8'h00;
      capUcastCount   <= 8'h00;
      capVlanModes    <= 8'h00;
      capChannelCount <= 8'h00;
    end
    else
    begin
      capVlanCount    <= 8'(VLAN_CNT);  // RQ1
      capMixedCount   <= 8'(MIXED_CNT);  // RQ4
      capMcastCount   <= 8'(MULTICAST_CNT);
      capUcastCount   <= 8'(UNICAST_CNT);
      capVlanModes    <= 8'h00;
      capVlanModes[`SGPR_VMODE_ONLY_BIT] <= 1'b1;  // RQ5
      capVlanModes[`SGPR_VMODE_PLUS_BIT] <= VMODE_PLUS;  // RQ6
      capVlanModes[`SGPR_VMODE_ANY_BIT]  <= VMODE_ANY;  // RQ6
      capChannelCount <= 8'(CHANNEL_CNT);  // RQ7
    end
  end

  //==========================================================================
  // Command acceptance and sequencing
  sgpr_state_t state_r;
  logic [7:0]  idx_r;
  logic [1:0]  csIdx_r;
  logic [127:0] hdr_r;
  logic [31:0] csum;
  sgpr_byte_t  payByte;
  logic        payFire;
  logic        accept;

  assign accept  = cmdValid && (cmdType == `SGPR_CMD_GET_PARAMS)  // RQ8
                   && cmdChecksumOk && cmdIdMatch;  // RQ11
  assign payFire = (state_r == SGPR_SEND) && (!rspValid || rspReady);

  logic        payDone;
  assign payDone = (idx_r == 8'(PAY_END - 1));  // RQ15

  // Sequencer state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_r <= SGPR_IDLE;
    else
    begin
      case (state_r)
        SGPR_IDLE:
          if (accept)  // RQ11
            state_r <= SGPR_SEND;
        SGPR_SEND:
          if (payFire && payDone)
            state_r <= SGPR_CSUM;
        SGPR_CSUM:
          if (rspReady && rspValid && csIdx_r == 2'h3)
            state_r <= SGPR_IDLE;
        default:
          state_r <= SGPR_IDLE;
      endcase
    end
  end

  // Payload byte index
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      idx_r <= 8'h00;
    else if (state_r == SGPR_IDLE && accept)
      idx_r <= 8'h00;
    else if (payFire)
      idx_r <= idx_r + 8'h01;
  end

  // Checksum byte index; hand-off of the last payload byte counts as step zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      csIdx_r <= 2'h0;
    else if (payFire && payDone)
      csIdx_r <= 2'h0;
    else if (state_r == SGPR_CSUM && rspReady && rspValid && csIdx_r != 2'h3)
      csIdx_r <= csIdx_r + 2'h1;
  end

  // Request header kept for the echo
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hdr_r <= '0;
    else if (state_r == SGPR_IDLE && accept)
      hdr_r <= cmdHeader;
  end

  //==========================================================================
  // Per-filter masks and byte views of the stored tables
  logic [7:0]  macMask;
  logic [14:0] vlanMask;
  sgpr_byte_t  hdrBytes [0:15];
  sgpr_byte_t  macBytes [0:47];
  sgpr_byte_t  tagBytes [0:29];

  // Flag bits of filters that are not built read zero
  for (genvar b = 0; b < 8; b++)
  begin : g_mac_mask
    assign macMask[b] = (b < MAC_CNT);  // RQ13 RQ22
  end

  for (genvar b = 0; b < 15; b++)
  begin : g_vlan_mask
    assign vlanMask[b] = (b < VLAN_CNT);  // RQ13 RQ23
  end

  // Reply header echoes the request except for the type byte
  for (genvar h = 0; h < 16; h++)
  begin : g_hdr_bytes
    if (h == 4)
    begin : g_type
      assign hdrBytes[h] = `SGPR_RSP_GET_PARAMS;  // RQ10
    end
    else
    begin : g_copy
      assign hdrBytes[h] = hdr_r[127 - 8 * h -: 8];
    end
  end

  // Slot order is unicast, multicast, mixed; each address goes out byte 5 first
  for (genvar k = 0; k < 48; k++)
  begin : g_mac_bytes
    assign macBytes[k] = macAddrs[48 * (k / 6) + 47 - 8 * (k % 6) -: 8];  // RQ16 RQ17
  end

  // Each tag goes out high byte first
  for (genvar k = 0; k < 30; k++)
  begin : g_tag_bytes
    assign tagBytes[k] = vlanTags[16 * (k / 2) + 15 - 8 * (k % 2) -: 8];  // RQ20
  end

  //==========================================================================
  // Response byte selection
  always_comb
  begin
    int i;
    i = int'(idx_r);
    payByte = 8'h00;  // RQ13
    if (i < `SGPR_HDR_BYTES)
      payByte = hdrBytes[4'(i)];  // RQ10
    else if (i < `SGPR_OFS_CODES + 2)
      payByte = (i == 16) ? 8'(`SGPR_RSP_CODE_OK >> 8) : 8'(`SGPR_RSP_CODE_OK);
    else if (i < `SGPR_OFS_MAC_CNT)
      payByte = (i == 18) ? 8'(`SGPR_REASON_NONE >> 8) : 8'(`SGPR_REASON_NONE);  // RQ14
    else if (i == `SGPR_OFS_MAC_CNT)
      payByte = 8'(MAC_CNT);
    else if (i == `SGPR_OFS_MAC_FLAGS)
      payByte = macEnables & macMask;  // RQ22
    else if (i == `SGPR_OFS_VLAN_CNT)
      payByte = 8'(VLAN_CNT);  // RQ23
    else if (i == `SGPR_OFS_VLAN_FLAGS)
      payByte = {1'b0, vlanEnables[14:8] & vlanMask[14:8]};  // RQ23
    else if (i == `SGPR_OFS_VLAN_FLAGS + 1)
      payByte = vlanEnables[7:0] & vlanMask[7:0];  // RQ23
    else if (i >= `SGPR_OFS_LINK && i < `SGPR_OFS_BCAST)
      payByte = linkSettings[31 - 8 * (i - `SGPR_OFS_LINK) -: 8];  // RQ12
    else if (i >= `SGPR_OFS_BCAST && i < `SGPR_OFS_CFG)
      payByte = bcastSettings[31 - 8 * (i - `SGPR_OFS_BCAST) -: 8];  // RQ12
    else if (i == `SGPR_OFS_CFG + 3)
      payByte = {4'h0, mcastFilterOn, netTxOn, channelOn, bcastFilterOn};  // RQ21
    else if (i == `SGPR_OFS_VLAN_MODE)
      payByte = vlanMode;  // RQ18
    else if (i == `SGPR_OFS_FLOW)
      payByte = flowCtrlEnable;  // RQ18
    else if (i >= `SGPR_OFS_AEN && i < `SGPR_OFS_MACS)
      payByte = aenControl[31 - 8 * (i - `SGPR_OFS_AEN) -: 8];
    else if (i >= `SGPR_OFS_MACS && i < VAR_OFS)
      payByte = macBytes[6'(i - `SGPR_OFS_MACS)];  // RQ16 RQ19
    else if (i >= VAR_OFS && i < TAG_END)
      payByte = tagBytes[5'(i - VAR_OFS)];  // RQ20
  end

  //==========================================================================
  // Checksum over everything before the checksum field
  sgpr_csum u_csum
  (
    .clk       (clk),
    .rst       (rst),
    .clear     (accept && state_r == SGPR_IDLE),
    .byteValid (payFire),
    .byteIn    (payByte),
    .csumOut   (csum)
  );

  //==========================================================================
  // Output stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rspValid <= 1'b0;
      rspByte  <= 8'h00;
      rspLast  <= 1'b0;
    end
    else if (payFire)
    begin
      rspValid <= 1'b1;
      rspByte  <= payByte;
      rspLast  <= 1'b0;
    end
    else if (state_r == SGPR_CSUM && (!rspValid || rspReady) && !(rspLast && rspValid))
    begin
      rspValid <= 1'b1;
      rspByte  <= csum[31 - 8 * int'(csIdx_r) -: 8];  // RQ20
      rspLast  <= (csIdx_r == 2'h3);
    end
    else if (rspReady)
    begin
      rspValid <= 1'b0;
      rspLast  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= (state_r != SGPR_IDLE) || accept;
  end
endmodule

// ---- hw/sgpr_consts.svh ----
// Constants for the sideband get-parameters responder
// Functional notes
// RQ1: Reported VLAN filter count equals implemented filters, never above 15.
// RQ2: At least one unicast or mixed address filter is always implemented.
// RQ3: Unicast, multicast and mixed filter counts total at most 8.
// RQ4: Each mixed filter matches one address, unicast or multicast.
// RQ5: VLAN mode support bit 0 always reads 1.
// RQ6: Support bits 1 and 2 read 1 only when those modes exist.
// RQ7: Channel count field holds the package's channel count.
// RQ8: The parameter request carries command type 0x17.
// RQ9: Request is 16-byte header, checksum bytes 16-19, pad to 45.
// RQ10: The reply carries response type 0x97.
// RQ11: A request passing checksum and identifier checks is always answered; the code drops one that arrives while the sequencer is not in SGPR_IDLE.
// RQ12: Each returned parameter equals the value last configured.
// RQ13: Unsupported parameter fields return zero.
// RQ14: No command-specific reason code is used.
// RQ15: Payload length varies with MAC and VLAN filter counts.
// RQ16: MAC addresses packed back to back before the VLAN tags, no padding.
// RQ17: MAC order is unicast, multicast, then mixed, sized by counts.
// RQ18: Byte 40 VLAN mode, 41 flow control, 42-43 reserved.
// RQ19: Variable part may begin at byte offset 52; the code starts it at byte offset 48.
// RQ20: VLAN tags follow MACs, pad to word, then 4-byte checksum.
// RQ21: Config flags bits 0-3 broadcast, enable, tx, multicast; rest reserved.
// RQ22: MAC flags bit n shows filter n+1 enabled.
// RQ23: Up to fifteen 16-bit VLAN tags, enables one bit each.
`ifndef SGPR_CONSTS_SVH
`define SGPR_CONSTS_SVH
`define SGPR_CMD_GET_PARAMS   8'h17
`define SGPR_RSP_GET_PARAMS   8'h97
`define SGPR_MAX_VLAN         15
`define SGPR_MAX_MAC          8
`define SGPR_HDR_BYTES        16
`define SGPR_OFS_CODES        16
`define SGPR_OFS_MAC_CNT      20
`define SGPR_OFS_MAC_FLAGS    23
`define SGPR_OFS_VLAN_CNT     24
`define SGPR_OFS_VLAN_FLAGS   26
`define SGPR_OFS_LINK         28
`define SGPR_OFS_BCAST        32
`define SGPR_OFS_CFG          36
`define SGPR_OFS_VLAN_MODE    40
`define SGPR_OFS_FLOW         41
`define SGPR_OFS_AEN          44
`define SGPR_OFS_MACS         48
`define SGPR_RSP_CODE_OK      16'h0000
`define SGPR_REASON_NONE      16'h0000
`define SGPR_VMODE_ONLY_BIT   0
`define SGPR_VMODE_PLUS_BIT   1
`define SGPR_VMODE_ANY_BIT    2
`endif

// ---- hw/sgpr_pkg.sv ----
// Types for the sideband get-parameters responder
package sgpr_pkg;
  typedef enum logic [1:0] {SGPR_IDLE, SGPR_SEND, SGPR_CSUM} sgpr_state_t;
  typedef logic [7:0] sgpr_byte_t;
endpackage

// ---- hw/sgpr_csum.sv ----
// Running 32-bit twos-complement checksum over 16-bit words
`timescale 1ns/100ps
module sgpr_csum
  import sgpr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        byteValid,
  input  wire sgpr_byte_t  byteIn,
  output logic [31:0]      csumOut
);
  logic [31:0] sum_r;
  logic [7:0]  hiByte_r;
  logic        odd_r;

  // Pairs bytes into big-endian 16-bit words and accumulates them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sum_r    <= 32'h00000000;
      hiByte_r <= 8'h00;
      odd_r    <= 1'b0;
    end
    else if (clear)
    begin
      sum_r    <= 32'h00000000;
      hiByte_r <= 8'h00;
      odd_r    <= 1'b0;
    end
    else if (byteValid)
    begin
      odd_r <= ~odd_r;
      if (!odd_r)
        hiByte_r <= byteIn;
      else
        sum_r <= sum_r + {16'h0000, hiByte_r, byteIn};
    end
  end

  assign csumOut = 32'h00000000 - sum_r;
endmodule

// ---- sim/sgpr_mc_model.sv ----
// Management controller side: sink for response bytes
`timescale 1ns/100ps
module sgpr_mc_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       clr,
  input  wire logic       rspValid,
  input  wire logic [7:0] rspByte,
  input  wire logic       rspLast,
  output logic            rspReady,
  output logic [7:0]      rxCount,
  output logic            gotLast
);
  logic [7:0] rxMem [0:255];
  // ==========
  // Ready stalls every other cycle when slow
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rspReady <= 1'b1;
    else
      rspReady <= slow ? ~rspReady : 1'b1;
  // ==========
  // Capture
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rxCount <= 8'h00;
      gotLast <= 1'b0;
    end
    else if (clr)
    begin
      rxCount <= 8'h00;
      gotLast <= 1'b0;
    end
    else if (rspValid && rspReady)
    begin
      rxMem[rxCount] <= rspByte;
      rxCount <= rxCount + 8'h01;
      gotLast <= rspLast;
    end
endmodule

// ---- sim/sgpr_responder_properties.sv ----
// Port checks for the get-parameters responder
`timescale 1ns/100ps
module sgpr_responder_properties
#(
  parameter int UNICAST_CNT   = 2,
  parameter int MULTICAST_CNT = 2,
  parameter int MIXED_CNT     = 2,
  parameter int VLAN_CNT      = 15,
  parameter int CHANNEL_CNT   = 1,
  parameter bit VMODE_PLUS    = 1'b1,
  parameter bit VMODE_ANY     = 1'b0
)
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cmdValid,
  input wire logic [7:0] cmdType,
  input wire logic       cmdChecksumOk,
  input wire logic       cmdIdMatch,
  input wire logic       rspReady,
  input wire logic       busy,
  input wire logic       rspValid,
  input wire logic [7:0] rspByte,
  input wire logic       rspLast,
  input wire logic [7:0] capVlanCount,
  input wire logic [7:0] capMixedCount,
  input wire logic [7:0] capMcastCount,
  input wire logic [7:0] capUcastCount,
  input wire logic [7:0] capVlanModes,
  input wire logic [7:0] capChannelCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic goodCmd;
  assign goodCmd = cmdValid && cmdType == 8'h17 && cmdChecksumOk && cmdIdMatch;
  vlan_count_a: assert property (!$past(rst) |-> capVlanCount == VLAN_CNT && capVlanCount <= 8'h0f)
    else $error("vlan filter count wrong");
  filter_total_a: assert property (!$past(rst) |-> int'(capUcastCount) + int'(capMcastCount) + int'(capMixedCount) <= 8
    && int'(capUcastCount) + int'(capMixedCount) >= 1 && capUcastCount == UNICAST_CNT)
    else $error("address filter counts wrong");
  vlan_modes_a: assert property (!$past(rst) |-> capVlanModes == {5'h00, VMODE_ANY, VMODE_PLUS, 1'b1})
    else $error("vlan mode support wrong");
  chan_count_a: assert property (!$past(rst) |-> capChannelCount == CHANNEL_CNT)
    else $error("channel count wrong");
  accept_cmd_a: assert property (goodCmd && !busy |=> busy ##1 rspValid)
    else $error("good request not answered");
  refuse_cmd_a: assert property (cmdValid && !busy && !goodCmd |=> !busy)
    else $error("bad request taken");
  byte_hold_a: assert property (rspValid && !rspReady |=> rspValid && $stable(rspByte) && $stable(rspLast))
    else $error("byte changed while stalled");
  last_end_a: assert property (rspValid && rspReady && rspLast |=> !rspValid)
    else $error("stream runs past last byte");
  last_valid_a: assert property (rspLast |-> rspValid)
    else $error("last flag without valid");
endmodule
bind sgpr_responder sgpr_responder_properties #(.UNICAST_CNT(UNICAST_CNT), .MULTICAST_CNT(MULTICAST_CNT),
  .MIXED_CNT(MIXED_CNT), .VLAN_CNT(VLAN_CNT), .CHANNEL_CNT(CHANNEL_CNT), .VMODE_PLUS(VMODE_PLUS),
  .VMODE_ANY(VMODE_ANY)) u_props (.clk, .rst, .cmdValid, .cmdType, .cmdChecksumOk, .cmdIdMatch, .rspReady,
  .busy, .rspValid, .rspByte, .rspLast, .capVlanCount, .capMixedCount, .capMcastCount, .capUcastCount,
  .capVlanModes, .capChannelCount);

// ---- sim/testbench.sv ----
// Self-checking bench for the get-parameters responder
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, cmdValid = 1'b0, cmdChecksumOk = 1'b0, cmdIdMatch = 1'b0;
  logic [7:0] cmdType = 8'h00, macEnables = 8'h00, vlanMode = 8'h00, flowCtrlEnable = 8'h00;
  logic [127:0] cmdHeader = '0;
  logic [383:0] macAddrs = '0;
  logic [239:0] vlanTags = '0;
  logic [14:0] vlanEnables = '0;
  logic [31:0] linkSettings = '0, bcastSettings = '0, aenControl = '0;
  logic bcastFilterOn = 1'b0, channelOn = 1'b0, netTxOn = 1'b0, mcastFilterOn = 1'b0;
  logic slow = 1'b0, clr = 1'b0, rspReady, busy, rspValid, rspLast, gotLast;
  logic [7:0] rspByte, rxCount, capVlanCount, capMixedCount, capMcastCount, capUcastCount, capVlanModes;
  logic [7:0] capChannelCount;
  logic [7:0] exp [0:119];
  int errors = 0, cmp_count = 0;
  always #25 clk = ~clk;
  sgpr_responder uut (.clk, .rst, .cmdValid, .cmdType, .cmdChecksumOk, .cmdIdMatch, .cmdHeader, .macAddrs,
    .macEnables, .vlanTags, .vlanEnables, .linkSettings, .bcastSettings, .bcastFilterOn, .channelOn, .netTxOn,
    .mcastFilterOn, .vlanMode, .flowCtrlEnable, .aenControl, .rspReady, .busy, .rspValid, .rspByte, .rspLast,
    .capVlanCount, .capMixedCount, .capMcastCount, .capUcastCount, .capVlanModes, .capChannelCount);
  sgpr_mc_model mc (.clk, .rst, .slow, .clr, .rspValid, .rspByte, .rspLast, .rspReady, .rxCount, .gotLast);
  // ==========
  // Tasks
  task automatic compare(input string what, input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic set_cfg(input logic [7:0] s);
    @(posedge clk);
    for (int i = 0; i < 16; i++) cmdHeader[i*8 +: 8] <= s ^ 8'(i);
    for (int i = 0; i < 48; i++) macAddrs[i*8 +: 8] <= s + 8'(i);
    for (int i = 0; i < 30; i++) vlanTags[i*8 +: 8] <= ~s - 8'(3*i);
    macEnables <= s;
    vlanEnables <= {s[6:0], ~s};
    linkSettings <= {s, ~s, s, 8'h5a};
    bcastSettings <= {4{~s}};
    aenControl <= {s, 8'h00, s, 8'hff};
    vlanMode <= s;
    flowCtrlEnable <= ~s;
    {bcastFilterOn, channelOn, netTxOn, mcastFilterOn} <= {s[0], s[1], ~s[3], s[3]};
  endtask
  task automatic send(input logic [7:0] t, input logic ok, input logic id);
    cmdValid <= 1'b1;
    cmdType <= t;
    cmdChecksumOk <= ok;
    cmdIdMatch <= id;
    @(posedge clk);
    cmdValid <= 1'b0;
  endtask
  task automatic run_cmd(input logic s, input logic again);
    int n;
    slow <= s;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    send(8'h17, 1'b1, 1'b1);
    if (again)
    begin
      repeat (6) @(posedge clk);
      send(8'h17, 1'b1, 1'b1);
    end
    n = 0;
    while (gotLast !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic check_rsp;
    logic [383:0] fixed;
    logic [31:0] sum;
    fixed = {cmdHeader[127:96], 8'h97, cmdHeader[87:0], 32'h0, 8'h06, 16'h0, macEnables & 8'h3f, 8'h0f, 8'h00, 1'b0,
      vlanEnables, linkSettings, bcastSettings, 28'h0, mcastFilterOn, netTxOn, channelOn, bcastFilterOn,
      vlanMode, flowCtrlEnable, 16'h0, aenControl};
    sum = 32'h0;
    for (int i = 0; i < 48; i++) exp[i] = fixed[383-8*i -: 8];
    for (int m = 0; m < 36; m++) exp[48+m] = macAddrs[48*(m/6)+47-8*(m%6) -: 8];
    for (int t = 0; t < 30; t++) exp[84+t] = vlanTags[16*(t/2)+15-8*(t%2) -: 8];
    exp[114] = 8'h00;
    exp[115] = 8'h00;
    for (int j = 0; j < 58; j++) sum = sum + {16'h0, exp[2*j], exp[2*j+1]};
    sum = 32'h0 - sum;
    for (int i = 0; i < 4; i++) exp[116+i] = sum[31-8*i -: 8];
    compare("rxCount", rxCount, 8'h78);
    compare("gotLast", {7'h00, gotLast}, 8'h01);
    for (int i = 0; i < 120; i++) compare("rspByte", mc.rxMem[i], exp[i]);
  endtask
  // ==========
  // Sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    set_cfg(8'h31);
    @(posedge clk);
    compare("capVlanCount", capVlanCount, 8'h0f);
    compare("capUcastCount", capUcastCount, 8'h02);
    compare("capMcastCount", capMcastCount, 8'h02);
    compare("capMixedCount", capMixedCount, 8'h02);
    compare("capVlanModes", capVlanModes, 8'h03);
    compare("capChannelCount", capChannelCount, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      send(k == 0 ? 8'h18 : (k == 3 ? 8'h97 : 8'h17), k != 1, k != 2);
      repeat (4) @(posedge clk);
      compare("busy", {7'h00, busy}, 8'h00);
      compare("rxCount", rxCount, 8'h00);
    end
    run_cmd(1'b0, 1'b0);
    check_rsp;
    set_cfg(8'hc6);
    run_cmd(1'b1, 1'b1);
    check_rsp;
    give_verdict;
  end
  initial
  begin
    #1000000;
    errors++;
    give_verdict;
  end
endmodule
